// >>> hw/pjc_regs.svh
// constants for the press judgement read and coil write command interpreter
`ifndef PJC_REGS_SVH
`define PJC_REGS_SVH
// ----------------------------------------
// framing characters
// ----------------------------------------
`define PJC_CHR_COLON 8'h3a
`define PJC_CHR_CR 8'h0d
`define PJC_CHR_LF 8'h0a
// ----------------------------------------
// message fields
// ----------------------------------------
`define PJC_FC_READ 8'h03
`define PJC_FC_COIL 8'h05
`define PJC_ADDR_BCAST 8'h00
`define PJC_JUDGE_ADDR 16'h9025
`define PJC_REG_COUNT 16'h0001
`define PJC_BYTE_COUNT 8'h02
`define PJC_COIL_ON 16'hff00
`define PJC_COIL_OFF 16'h0000
`define PJC_FRAME_BYTES 4'h7
`define PJC_READ_BYTES 4'h6
`define PJC_FRAME_NIBS 5'h0e
// ----------------------------------------
// judgement word fields
// ----------------------------------------
`define PJC_JUDGE_PAD 10'h000
// ----------------------------------------
// coil addresses and output bit positions
// ----------------------------------------
`define PJC_COIL_SAFE_SPEED 16'h0401
`define PJC_COIL_SERVO 16'h0403
`define PJC_COIL_FAULT_CLR 16'h0407
`define PJC_COIL_BRAKE 16'h0408
`define PJC_COIL_PAUSE 16'h040a
`define PJC_COIL_HOME 16'h040b
`define PJC_COIL_POS_GO 16'h040c
`define PJC_COIL_JOG_INCH 16'h0411
`define PJC_COIL_TEACH 16'h0414
`define PJC_COIL_CAPTURE 16'h0415
`define PJC_COIL_JOG_PLUS 16'h0416
`define PJC_COIL_JOG_MINUS 16'h0417
`define PJC_COIL_VALVE_FIRST 16'h0418
`define PJC_COIL_VALVE_LAST 16'h041f
`define PJC_COIL_CALIB 16'h0426
`define PJC_COIL_IO_LINK 16'h0427
`define PJC_COIL_DECEL 16'h042c
`define PJC_COIL_PRG_FIRST 16'h049b
`define PJC_COIL_PRG_LAST 16'h049f
`define PJC_IDX_SAFE_SPEED 5'h00
`define PJC_IDX_VALVE_BASE 5'h0c
`define PJC_IDX_CALIB 5'h14
`define PJC_IDX_PRG_BASE 5'h17
`define PJC_NUM_COILS 28
`endif

// >>> hw/pjc_pkg.sv
// types for the press judgement read and coil write command interpreter
package pjc_pkg;
   // receive parser states
   typedef enum logic [1:0] {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01,
      RX_LF = 2'b10,
      RX_EXEC = 2'b11
   } pjc_rx_state_t;
   // transmit sequencer states
   typedef enum logic [2:0] {
      TX_IDLE = 3'b000,
      TX_BUILD = 3'b001,
      TX_COLON = 3'b010,
      TX_LOAD = 3'b011,
      TX_HI = 3'b100,
      TX_LO = 3'b101,
      TX_CR = 3'b110,
      TX_LF = 3'b111
   } pjc_tx_state_t;
endpackage

// >>> hw/pjc_mem_if.sv
// carrier between the interpreter and its response byte memory
`timescale 1ns/1ps
interface pjc_mem_if #(parameter int AW = 3, parameter int DW = 8);
   logic wr_en; // write strobe
   logic [AW-1:0] wr_addr; // write slot
   logic [DW-1:0] wr_data; // write byte
   logic [AW-1:0] rd_addr; // read slot
   logic [DW-1:0] rd_data; // registered read byte
   modport user (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
   modport mem (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

// >>> hw/pjc_resp_mem.sv
// small response byte memory with registered read port
`timescale 1ns/1ps
module pjc_resp_mem #(
   parameter int AW = 3,
   parameter int DW = 8
) (
   // clock
   input wire logic clk,
   // access port
   pjc_mem_if.mem m
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   logic [DW-1:0] mem_q [2**AW]; // byte slots
   logic [DW-1:0] rd_q; // read register

   // write and registered read
   always_ff @(posedge clk) begin
      if (m.wr_en) begin
         mem_q[m.wr_addr] <= m.wr_data;
      end
      rd_q <= mem_q[m.rd_addr];
   end

   assign m.rd_data = rd_q;
endmodule

// >>> hw/pjc_core.sv
// ascii framed judgement status read and single coil write slave
`timescale 1ns/1ps
`include "pjc_regs.svh"
module pjc_core #(
   parameter int SPD_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // station address, 01 to 10 hex
   input wire logic [7:0] slave_addr,
   // received characters
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   // transmitted characters
   output logic [7:0] tx_byte,
   output logic tx_valid,
   input wire logic tx_ready,
   // judgement flags
   input wire logic overall_judge_pass,
   input wire logic overall_judge_fail,
   input wire logic position_judge_pass,
   input wire logic position_judge_fail,
   input wire logic load_judge_pass,
   input wire logic load_judge_fail,
   // coil outputs
   output logic [`PJC_NUM_COILS-1:0] coil_out,
   // speed limiting
   input wire logic manual_operation_mode,
   input wire logic [SPD_W-1:0] safety_speed_cfg,
   input wire logic [SPD_W-1:0] move_speed_req,
   output logic [SPD_W-1:0] move_speed_out
);
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // ascii hex character to nibble, bit 4 flags a valid digit
   function automatic logic [4:0] hex_val(input logic [7:0] c);
      if (c >= 8'h30 && c <= 8'h39) return {1'b1, c[3:0]};
      else if ((c >= 8'h41 && c <= 8'h46) || (c >= 8'h61 && c <= 8'h66)) return {1'b1, c[3:0] + 4'h9};
      else return 5'h00;
   endfunction
   // nibble to upper case ascii hex
   function automatic logic [7:0] hex_chr(input logic [3:0] n);
      return (n < 4'ha) ? {4'h3, n} : {4'h4, n - 4'h9};
   endfunction
   // coil address to output bit, bit 5 flags a known coil
   function automatic logic [5:0] coil_idx(input logic [15:0] a);
      logic [15:0] v;
      v = a - `PJC_COIL_VALVE_FIRST;
      case (a)
         `PJC_COIL_SAFE_SPEED: return 6'h20;
         `PJC_COIL_SERVO: return 6'h21;
         `PJC_COIL_FAULT_CLR: return 6'h22;
         `PJC_COIL_BRAKE: return 6'h23;
         `PJC_COIL_PAUSE: return 6'h24;
         `PJC_COIL_HOME: return 6'h25;
         `PJC_COIL_POS_GO: return 6'h26;
         `PJC_COIL_JOG_INCH: return 6'h27;
         `PJC_COIL_TEACH: return 6'h28;
         `PJC_COIL_CAPTURE: return 6'h29;
         `PJC_COIL_JOG_PLUS: return 6'h2a;
         `PJC_COIL_JOG_MINUS: return 6'h2b;
         `PJC_COIL_CALIB: return {1'b1, `PJC_IDX_CALIB};
         `PJC_COIL_IO_LINK: return 6'h35;
         `PJC_COIL_DECEL: return 6'h36;
         default: begin
            if (a >= `PJC_COIL_VALVE_FIRST && a <= `PJC_COIL_VALVE_LAST) begin
               return {1'b1, `PJC_IDX_VALVE_BASE + v[4:0]};
            end else if (a >= `PJC_COIL_PRG_FIRST && a <= `PJC_COIL_PRG_LAST) begin
               v = a - `PJC_COIL_PRG_FIRST;
               return {1'b1, `PJC_IDX_PRG_BASE + v[4:0]};
            end else begin
               return 6'h00;
            end
         end
      endcase
   endfunction

   // ----------------------------------------
   // receive parser state
   // ----------------------------------------
   pjc_pkg::pjc_rx_state_t rx_st_q, rx_st_d; // parser state
   logic [7:0] frame_q [8]; // received binary bytes
   logic [7:0] frame_d [8];
   logic [4:0] nib_q, nib_d; // nibble count, saturating
   logic [`PJC_NUM_COILS-1:0] coil_q, coil_d; // coil states
   logic start_d; // launch a reply
   logic echo_d; // reply is an echo
   logic [7:0] lrc_sum; // byte sum of received frame
   logic [4:0] hv; // decoded character
   logic [5:0] cidx; // decoded coil
   logic [15:0] f_start; // start or coil address field
   logic [15:0] f_data; // count or written data field
   logic tx_idle; // transmitter free

   assign hv = hex_val(rx_byte);
   assign f_start = {frame_q[2], frame_q[3]};
   assign f_data = {frame_q[4], frame_q[5]};
   assign cidx = coil_idx(f_start);

   // sum of the seven frame bytes, zero when the check byte fits
   always_comb begin
      lrc_sum = 8'h00;
      for (int i = 0; i < 7; i++) begin
         lrc_sum = lrc_sum + frame_q[i];
      end
   end

   // parser next state and command execution
   always_comb begin
      rx_st_d = rx_st_q;
      frame_d = frame_q;
      nib_d = nib_q;
      coil_d = coil_q;
      start_d = 1'b0;
      echo_d = 1'b0;
      case (rx_st_q)
         pjc_pkg::RX_IDLE: begin
            nib_d = 5'h00;
         end
         pjc_pkg::RX_DATA: begin
            if (rx_valid && rx_byte == `PJC_CHR_CR) begin
               rx_st_d = pjc_pkg::RX_LF;
            end else if (rx_valid && hv[4]) begin
               // collect nibbles, overflow marks the frame bad
               if (nib_q < 5'h10) begin
                  if (nib_q[0]) frame_d[nib_q[3:1]][3:0] = hv[3:0];
                  else frame_d[nib_q[3:1]][7:4] = hv[3:0];
                  nib_d = nib_q + 5'h01;
               end
            end else if (rx_valid) begin
               rx_st_d = pjc_pkg::RX_IDLE; // junk character drops frame
            end
         end
         pjc_pkg::RX_LF: begin
            if (rx_valid) begin
               rx_st_d = (rx_byte == `PJC_CHR_LF) ? pjc_pkg::RX_EXEC : pjc_pkg::RX_IDLE;
            end
         end
         pjc_pkg::RX_EXEC: begin
            rx_st_d = pjc_pkg::RX_IDLE;
            if (nib_q == `PJC_FRAME_NIBS && lrc_sum == 8'h00) begin
               if (frame_q[1] == `PJC_FC_READ && frame_q[0] == slave_addr &&
                   f_start == `PJC_JUDGE_ADDR && f_data == `PJC_REG_COUNT) begin
                  start_d = tx_idle;
               end else if (frame_q[1] == `PJC_FC_COIL && cidx[5] &&
                            (frame_q[0] == slave_addr || frame_q[0] == `PJC_ADDR_BCAST) &&
                            (f_data == `PJC_COIL_ON || f_data == `PJC_COIL_OFF)) begin
                  coil_d[cidx[4:0]] = (f_data == `PJC_COIL_ON);
                  start_d = tx_idle && frame_q[0] != `PJC_ADDR_BCAST;
                  echo_d = 1'b1;
               end
            end
         end
         default: rx_st_d = pjc_pkg::RX_IDLE;
      endcase
      // a header restarts the frame in every state but RX_EXEC
      if (rx_valid && rx_byte == `PJC_CHR_COLON && rx_st_q != pjc_pkg::RX_EXEC) begin
         rx_st_d = pjc_pkg::RX_DATA;
         nib_d = 5'h00;
      end
   end

   // parser registers
   always_ff @(posedge clk) begin
      if (srst) begin
         rx_st_q <= pjc_pkg::RX_IDLE;
         nib_q <= 5'h00;
         coil_q <= '0;
         for (int i = 0; i < 8; i++) frame_q[i] <= 8'h00;
      end else begin
         rx_st_q <= rx_st_d;
         nib_q <= nib_d;
         coil_q <= coil_d;
         frame_q <= frame_d;
      end
   end

   assign coil_out = coil_q;

   // ----------------------------------------
   // response memory
   // ----------------------------------------
   pjc_mem_if #(.AW(3), .DW(8)) mif ();
   pjc_resp_mem #(.AW(3), .DW(8)) u_mem (
      .clk(clk),
      .m(mif.mem)
   );

   // ----------------------------------------
   // transmit sequencer state
   // ----------------------------------------
   pjc_pkg::pjc_tx_state_t tx_st_q, tx_st_d; // sequencer state
   logic echo_q, echo_d2; // reply is an echo
   logic [15:0] judge_q, judge_d; // judgement snapshot
   logic [2:0] idx_q, idx_d; // byte slot
   logic [7:0] sum_q, sum_d; // running reply sum
   logic [7:0] txb_q, txb_d; // outgoing character
   logic txv_q, txv_d; // character valid
   logic [3:0] nbytes; // reply length in bytes
   logic [7:0] src; // byte being built

   assign tx_idle = (tx_st_q == pjc_pkg::TX_IDLE);
   assign nbytes = echo_q ? `PJC_FRAME_BYTES : `PJC_READ_BYTES;

   // reply byte source for the build pass
   always_comb begin
      case (idx_q)
         3'h0: src = echo_q ? frame_q[0] : slave_addr;
         3'h1: src = echo_q ? frame_q[1] : `PJC_FC_READ;
         3'h2: src = echo_q ? frame_q[2] : `PJC_BYTE_COUNT;
         3'h3: src = echo_q ? frame_q[3] : judge_q[15:8];
         3'h4: src = echo_q ? frame_q[4] : judge_q[7:0];
         default: src = frame_q[idx_q];
      endcase
   end

   // sequencer next state
   always_comb begin
      tx_st_d = tx_st_q;
      echo_d2 = echo_q;
      judge_d = judge_q;
      idx_d = idx_q;
      sum_d = sum_q;
      txb_d = txb_q;
      txv_d = txv_q && !tx_ready;
      mif.wr_en = 1'b0;
      mif.wr_addr = idx_q;
      mif.wr_data = src;
      mif.rd_addr = idx_q;
      case (tx_st_q)
         pjc_pkg::TX_IDLE: begin
            if (start_d) begin
               tx_st_d = pjc_pkg::TX_BUILD;
               echo_d2 = echo_d;
               judge_d = {`PJC_JUDGE_PAD, load_judge_fail, load_judge_pass, position_judge_fail,
                          position_judge_pass, overall_judge_fail, overall_judge_pass};
               idx_d = 3'h0;
               sum_d = 8'h00;
            end
         end
         pjc_pkg::TX_BUILD: begin
            // last slot carries the negated sum
            mif.wr_en = 1'b1;
            if ({1'b0, idx_q} == nbytes - 4'h1) begin
               mif.wr_data = 8'h00 - sum_q;
               tx_st_d = pjc_pkg::TX_COLON;
               idx_d = 3'h0;
            end else begin
               sum_d = sum_q + src;
               idx_d = idx_q + 3'h1;
            end
         end
         pjc_pkg::TX_COLON: begin
            if (!txv_q) begin
               txb_d = `PJC_CHR_COLON;
               txv_d = 1'b1;
               tx_st_d = pjc_pkg::TX_LOAD;
            end
         end
         pjc_pkg::TX_LOAD: begin
            tx_st_d = pjc_pkg::TX_HI; // read data arrives next cycle
         end
         pjc_pkg::TX_HI: begin
            if (!txv_d) begin
               txb_d = hex_chr(mif.rd_data[7:4]);
               txv_d = 1'b1;
               tx_st_d = pjc_pkg::TX_LO;
            end
         end
         pjc_pkg::TX_LO: begin
            if (!txv_d) begin
               txb_d = hex_chr(mif.rd_data[3:0]);
               txv_d = 1'b1;
               idx_d = idx_q + 3'h1;
               tx_st_d = ({1'b0, idx_q} == nbytes - 4'h1) ? pjc_pkg::TX_CR : pjc_pkg::TX_LOAD;
            end
         end
         pjc_pkg::TX_CR: begin
            if (!txv_d) begin
               txb_d = `PJC_CHR_CR;
               txv_d = 1'b1;
               tx_st_d = pjc_pkg::TX_LF;
            end
         end
         pjc_pkg::TX_LF: begin
            if (!txv_d) begin
               txb_d = `PJC_CHR_LF;
               txv_d = 1'b1;
               tx_st_d = pjc_pkg::TX_IDLE;
            end
         end
         default: tx_st_d = pjc_pkg::TX_IDLE;
      endcase
   end

   // sequencer registers
   always_ff @(posedge clk) begin
      if (srst) begin
         tx_st_q <= pjc_pkg::TX_IDLE;
         echo_q <= 1'b0;
         judge_q <= 16'h0000;
         idx_q <= 3'h0;
         sum_q <= 8'h00;
         txb_q <= 8'h00;
         txv_q <= 1'b0;
      end else begin
         tx_st_q <= tx_st_d;
         echo_q <= echo_d2;
         judge_q <= judge_d;
         idx_q <= idx_d;
         sum_q <= sum_d;
         txb_q <= txb_d;
         txv_q <= txv_d;
      end
   end

   assign tx_byte = txb_q;
   assign tx_valid = txv_q;

   // ----------------------------------------
   // safety speed limiting
   // ----------------------------------------
   logic [SPD_W-1:0] spd_q, spd_d; // limited speed

   // cap requested speed while safety speed and manual mode
   always_comb begin
      spd_d = move_speed_req;
      if (coil_q[`PJC_IDX_SAFE_SPEED] && manual_operation_mode && move_speed_req > safety_speed_cfg) begin
         spd_d = safety_speed_cfg;
      end
   end

   // speed register
   always_ff @(posedge clk) begin
      if (srst) spd_q <= '0;
      else spd_q <= spd_d;
   end

   assign move_speed_out = spd_q;
endmodule

// >>> bench/pjc_core_props.sv
// assertion checker for the judgement read and coil write interpreter
`timescale 1ns/1ps
`include "pjc_regs.svh"
module pjc_core_props #(
   parameter int SPD_W = 16
) (
   // clock and reset
   input wire logic clk,
   input wire logic srst,
   // character links
   input wire logic [7:0] rx_byte,
   input wire logic rx_valid,
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   input wire logic tx_ready,
   // coils and speed
   input wire logic [`PJC_NUM_COILS-1:0] coil_out,
   input wire logic manual_operation_mode,
   input wire logic [SPD_W-1:0] safety_speed_cfg,
   input wire logic [SPD_W-1:0] move_speed_req,
   input wire logic [SPD_W-1:0] move_speed_out
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (srst);
   logic lf_seen; // frame trailer taken this cycle
   logic cap_now; // speed limit applies this cycle
   assign lf_seen = rx_valid && rx_byte == `PJC_CHR_LF;
   assign cap_now = manual_operation_mode && coil_out[0] && move_speed_req > safety_speed_cfg;
   // ----------------------------------------
   // properties
   // ----------------------------------------
   property p_reset_clears;
      disable iff (1'b0) srst |=> !tx_valid && coil_out == '0 && move_speed_out == '0;
   endproperty
   property p_tx_holds;
      tx_valid && !tx_ready |=> tx_valid && $stable(tx_byte);
   endproperty
   // hex characters may follow back to back, but a reply never runs on past its line feed
   property p_tx_gap;
      tx_valid && tx_ready && tx_byte == `PJC_CHR_LF |=> !tx_valid;
   endproperty
   property p_tx_charset;
      tx_valid |-> tx_byte inside {`PJC_CHR_COLON, `PJC_CHR_CR, `PJC_CHR_LF, [8'h30:8'h39], [8'h41:8'h46]};
   endproperty
   property p_trailer_order;
      tx_valid && tx_ready && tx_byte == `PJC_CHR_CR |-> ##[1:3] tx_valid && tx_byte == `PJC_CHR_LF;
   endproperty
   property p_coil_after_frame;
      $changed(coil_out) |-> $past(lf_seen, 1) || $past(lf_seen, 2) || $past(lf_seen, 3);
   endproperty
   property p_one_coil;
      $changed(coil_out) |-> $onehot(coil_out ^ $past(coil_out));
   endproperty
   property p_speed_cap;
      !srst |=> move_speed_out == ($past(cap_now) ? $past(safety_speed_cfg) : $past(move_speed_req));
   endproperty
   // ----------------------------------------
   // assertions and covers
   // ----------------------------------------
   a_reset_clears: assert property (p_reset_clears) else $error("outputs not cleared by reset");
   a_tx_holds: assert property (p_tx_holds) else $error("reply character dropped before accept");
   a_tx_gap: assert property (p_tx_gap) else $error("reply character repeated after accept");
   a_tx_charset: assert property (p_tx_charset) else $error("illegal reply character");
   a_trailer_order: assert property (p_trailer_order) else $error("line feed missing after return");
   a_coil_after_frame: assert property (p_coil_after_frame) else $error("coil changed outside a frame");
   a_one_coil: assert property (p_one_coil) else $error("several coils changed at once");
   a_speed_cap: assert property (p_speed_cap) else $error("speed output wrong");
   c_reply_end: cover property (tx_valid && tx_ready && tx_byte == `PJC_CHR_LF);
   c_reply_stall: cover property (tx_valid && !tx_ready);
   c_speed_capped: cover property (cap_now);
endmodule
bind pjc_core pjc_core_props #(.SPD_W(SPD_W)) pjc_core_props_i (
   .clk(clk), .srst(srst), .rx_byte(rx_byte), .rx_valid(rx_valid), .tx_byte(tx_byte),
   .tx_valid(tx_valid), .tx_ready(tx_ready), .coil_out(coil_out), .manual_operation_mode(manual_operation_mode),
   .safety_speed_cfg(safety_speed_cfg), .move_speed_req(move_speed_req), .move_speed_out(move_speed_out)
);

// >>> bench/pjc_host_model.sv
// host master model: sends frames, collects replies
`timescale 1ns/1ps
module pjc_host_model (
   // clock
   input wire logic clk,
   // characters to the slave
   output logic [7:0] rx_byte,
   output logic rx_valid,
   // characters from the slave
   input wire logic [7:0] tx_byte,
   input wire logic tx_valid,
   output logic tx_ready
);
   bit slow = 1'b0; // stall the sink every other cycle
   string got = ""; // reply so far
   string ch = " "; // one reply character
   string digits = "0123456789ABCDEF"; // hex character table
   initial begin
      rx_byte = 8'h00;
      rx_valid = 1'b0;
      tx_ready = 1'b0;
   end
   // reply sink
   always @(posedge clk) begin
      if (tx_valid && tx_ready) begin
         ch.putc(0, tx_byte);
         got = {got, ch};
      end
      tx_ready <= slow ? ~tx_ready : 1'b1;
   end
   // two upper case hex characters
   function automatic string hex2(input logic [7:0] b);
      string s;
      s = "00";
      s.putc(0, digits[b[7:4]]);
      s.putc(1, digits[b[3:0]]);
      return s;
   endfunction
   // whole frame from its hex body, check optionally spoiled
   function automatic string frame(input string body, input bit bad);
      logic [7:0] sum;
      sum = 8'h00;
      for (int i = 0; i < body.len(); i += 2) begin
         sum = sum + 8'(body.substr(i, i + 1).atohex());
      end
      sum = 8'h00 - sum;
      sum = sum + {7'h00, bad};
      return {":", body, hex2(sum), "\r\n"};
   endfunction
   // one character a cycle, then line idles away from last value
   task automatic send(input string f);
      for (int i = 0; i < f.len(); i++) begin
         @(posedge clk);
         rx_byte <= f[i];
         rx_valid <= 1'b1;
      end
      @(posedge clk);
      rx_byte <= ~rx_byte;
      rx_valid <= 1'b0;
   endtask
endmodule

// >>> bench/press_judgement_and_coil_cmd_tb.sv
// self-checking bench for the judgement read and coil write interpreter
`timescale 1ns/1ps
`include "pjc_regs.svh"
module press_judgement_and_coil_cmd_tb;
   logic clk = 1'b0;
   logic srst = 1'b1;
   logic [7:0] slave_addr = 8'h01;
   logic [5:0] judge = 6'h00; // flags in status word order
   logic manual = 1'b0;
   logic [15:0] cfg = 16'h0100;
   logic [15:0] req = 16'h0050;
   logic [7:0] rx_byte, tx_byte;
   logic rx_valid, tx_valid, tx_ready;
   logic [`PJC_NUM_COILS-1:0] coil_out;
   logic [15:0] speed;
   int mismatches = 0;
   int comparisons = 0;
   string f, r;
   // coil address of each output bit, row = bit
   localparam logic [15:0] COILS [28] = '{16'h0401, 16'h0403, 16'h0407, 16'h0408, 16'h040a, 16'h040b,
      16'h040c, 16'h0411, 16'h0414, 16'h0415, 16'h0416, 16'h0417, 16'h0418, 16'h0419, 16'h041a, 16'h041b,
      16'h041c, 16'h041d, 16'h041e, 16'h041f, 16'h0426, 16'h0427, 16'h042c, 16'h049b, 16'h049c, 16'h049d,
      16'h049e, 16'h049f};
   // refused frames: spoiled check, bad data, other station, unknown coil, broadcast read
   string bad_bodies [5] = '{"010504010000", "010504011234", "020504010000", "010504020000", "000390250001"};
   always #20 clk = ~clk;
   pjc_core pjc_core_i (.clk(clk), .srst(srst), .slave_addr(slave_addr), .rx_byte(rx_byte),
      .rx_valid(rx_valid), .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready),
      .overall_judge_pass(judge[0]), .overall_judge_fail(judge[1]), .position_judge_pass(judge[2]),
      .position_judge_fail(judge[3]), .load_judge_pass(judge[4]), .load_judge_fail(judge[5]),
      .coil_out(coil_out), .manual_operation_mode(manual), .safety_speed_cfg(cfg),
      .move_speed_req(req), .move_speed_out(speed));
   pjc_host_model pjc_host_model_i (.clk(clk), .rx_byte(rx_byte), .rx_valid(rx_valid),
      .tx_byte(tx_byte), .tx_valid(tx_valid), .tx_ready(tx_ready));
   // ----------------------------------------
   // compare and transfer tasks
   // ----------------------------------------
   task automatic give_verdict();
      $display("comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   task automatic check_str(input string got, input string exp);
      comparisons++;
      if (got != exp) begin
         mismatches++;
         $display("Error at %0t: reply of %0d characters differs from expected", $time, got.len());
      end
   endtask
   task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         mismatches++;
         $display("Error at %0t: value %h expected %h", $time, got, exp);
      end
   endtask
   // sends a frame, waits up to 200 cycles for n reply characters, then 40 cycles more
   task automatic xfer(input string fr, input int n, output string rep);
      pjc_host_model_i.got = "";
      pjc_host_model_i.send(fr);
      for (int i = 0; i < 200 && pjc_host_model_i.got.len() < n; i++) @(posedge clk);
      repeat (40) @(posedge clk);
      if (pjc_host_model_i.got.len() < n) begin
         mismatches++;
         give_verdict();
      end
      @(negedge clk);
      rep = pjc_host_model_i.got;
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (10) @(posedge clk);
      @(negedge clk);
      check_val({31'h0, tx_valid}, 0);
      check_val({4'h0, coil_out}, 0);
      check_val({16'h0, speed}, 0);
      @(posedge clk);
      srst <= 1'b0;
      // every coil on then off
      foreach (COILS[i]) begin
         for (int v = 0; v < 2; v++) begin
            f = pjc_host_model_i.frame({"0105", pjc_host_model_i.hex2(COILS[i][15:8]),
               pjc_host_model_i.hex2(COILS[i][7:0]), v ? "0000" : "FF00"}, 1'b0);
            xfer(f, 17, r);
            check_str(r, f);
            check_val({4'h0, coil_out}, v ? 32'h0 : 32'h1 << i);
         end
      end
      // judgement reads, second one with a stalling sink
      for (int j = 0; j < 2; j++) begin
         judge <= j ? 6'h1a : 6'h25;
         pjc_host_model_i.slow = j[0];
         xfer(pjc_host_model_i.frame("010390250001", 1'b0), 15, r);
         check_str(r, pjc_host_model_i.frame({"01030200", j ? "1A" : "25"}, 1'b0));
      end
      pjc_host_model_i.slow = 1'b0;
      // broadcast in lower case hex applies without reply
      xfer(pjc_host_model_i.frame("00050401ff00", 1'b0), 0, r);
      check_str(r, "");
      check_val({4'h0, coil_out}, 1);
      // refused frames leave the coil that is on unchanged, and stay silent
      foreach (bad_bodies[k]) begin
         xfer(pjc_host_model_i.frame(bad_bodies[k], k == 0), 0, r);
         check_str(r, "");
         check_val({4'h0, coil_out}, 1);
      end
      // speed capping in manual mode
      manual <= 1'b1;
      req <= 16'h0300;
      repeat (3) @(negedge clk);
      check_val({16'h0, speed}, 32'h0100);
      manual <= 1'b0;
      repeat (3) @(negedge clk);
      check_val({16'h0, speed}, 32'h0300);
      // reset in mid-run clears outputs, then a read still works
      srst <= 1'b1;
      repeat (2) @(negedge clk);
      check_val({4'h0, coil_out}, 0);
      check_val({16'h0, speed}, 0);
      srst <= 1'b0;
      xfer(pjc_host_model_i.frame("010390250001", 1'b0), 15, r);
      check_str(r, pjc_host_model_i.frame("010302001A", 1'b0));
      give_verdict();
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge clk);
      mismatches++;
      give_verdict();
   end
endmodule
